// file: verilog/option_cfg_pkg.sv
// Package with option byte layout, reset values and decode encodings
package option_cfg_pkg;
    localparam logic [7:0] CFG0_RESET      = 8'hFC;
    localparam logic [7:0] CFG1_RESET      = 8'hEF;
    // Byte one fields
    localparam int         PLL_FACTOR_BIT  = 7;
    localparam int         PLL_BYPASS_BIT  = 6;
    localparam int         RESERVED1_BIT   = 5;
    localparam int         RC_OSC_DIS_BIT  = 4;
    localparam int         SMON_HI_BIT     = 3;
    localparam int         SMON_LO_BIT     = 2;
    localparam int         WDG_TYPE_BIT    = 1;
    localparam int         WDG_HALT_BIT    = 0;
    // Byte zero fields
    localparam int         SEC_HI_BIT      = 3;
    localparam int         SEC_LO_BIT      = 2;
    localparam int         RDP_BIT         = 1;
    localparam int         WRP_BIT         = 0;
    localparam logic [3:0] RESERVED0_MASK  = 4'hF;
    // Supply monitor codes
    localparam logic [1:0] SMON_OFF        = 2'h3;
    localparam logic [1:0] SMON_HIGH       = 2'h2;
    localparam logic [1:0] SMON_MED        = 2'h1;
    localparam logic [1:0] SMON_LOW        = 2'h0;
    // Sector 0 size codes, in half kilobytes
    localparam logic [1:0] SEC_HALF_K      = 2'h1;
    localparam logic [1:0] SEC_ONE_K       = 2'h2;
    localparam logic [1:0] SEC_ONE_HALF_K  = 2'h3;
    // Cycles held in load state after reset release before the core may run
    localparam logic [3:0] LOAD_CYCLES     = 4'h2;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_LOAD,
        ST_RUN,
        ST_ERASE
    } cfg_state_t;
endpackage

// file: verilog/option_field_decode.sv
// Combinational decode of the two option bytes into hardware settings
`timescale 1ns/10ps
module option_field_decode (
    input  wire logic [7:0] cfg0,
    input  wire logic [7:0] cfg1,
    output logic            pll_factor_sel,
    output logic            pll_bypass,
    output logic            rc_osc_disable,
    output logic [1:0]      supply_monitor_threshold,
    output logic            supply_monitor_enable,
    output logic            watchdog_type_sel,
    output logic            halt_reset_enable,
    output logic [1:0]      sector0_size,
    output logic            readout_protect,
    output logic            program_write_protect
);
    // Sector code 1x always gives the largest sector
    function automatic logic [1:0] sector_decode(input logic [1:0] code);
        case (code)
            2'h0:    sector_decode = option_cfg_pkg::SEC_HALF_K;
            2'h1:    sector_decode = option_cfg_pkg::SEC_ONE_K;
            default: sector_decode = option_cfg_pkg::SEC_ONE_HALF_K;
        endcase
    endfunction

    // Field extraction
    always_comb begin
        pll_factor_sel           = cfg1[option_cfg_pkg::PLL_FACTOR_BIT];
        pll_bypass               = cfg1[option_cfg_pkg::PLL_BYPASS_BIT];
        rc_osc_disable           = cfg1[option_cfg_pkg::RC_OSC_DIS_BIT];
        supply_monitor_threshold = {cfg1[option_cfg_pkg::SMON_HI_BIT],
                                    cfg1[option_cfg_pkg::SMON_LO_BIT]};
        supply_monitor_enable    = (supply_monitor_threshold
                                    != option_cfg_pkg::SMON_OFF);
        watchdog_type_sel        = cfg1[option_cfg_pkg::WDG_TYPE_BIT];
        halt_reset_enable        = cfg1[option_cfg_pkg::WDG_HALT_BIT];
        sector0_size             = sector_decode({cfg0[option_cfg_pkg::SEC_HI_BIT],
                                                  cfg0[option_cfg_pkg::SEC_LO_BIT]});
        readout_protect          = cfg0[option_cfg_pkg::RDP_BIT];
        program_write_protect    = cfg0[option_cfg_pkg::WRP_BIT];
    end
endmodule

// file: verilog/option_byte_config_decode.sv
// Option byte store, reset-time latch and decoded configuration outputs
`timescale 1ns/10ps
// How it works
// - Byte one bit 7 picks the PLL factor, 0 for times four and 1 for times eight.
// - Byte one bit 6 at 0 keeps the PLL in the clock path and at 1 bypasses it.
// - Byte one bit 4 at 0 runs the RC oscillator, at 1 stops it and uses the external clock.
// - Byte one bits 3:2 give supply monitor off (11), high (10), medium (01) or low (00).
// - Byte one bit 1 at 0 makes the watchdog run from reset and software cannot stop it.
// - Byte one bit 1 at 1 leaves the watchdog off until software enables it.
// - Byte one bit 0 at 1 makes Halt entry with an active watchdog cause a reset.
// - Byte zero bits 3:2 size sector 0 as 0.5k (00), 1k (01) or 1.5k (1x).
// - Byte zero bit 1 blocks program memory read-out and writes; erasing it erases all first.
// - Byte zero bit 0 write-protects program memory and itself for good.
// - Option bytes are written only in programming mode.
module option_byte_config_decode (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       prog_mode,
    input  wire logic       opt_wr,
    input  wire logic       opt_erase,
    input  wire logic       opt_sel,
    input  wire logic [7:0] opt_wdata,
    output logic      [7:0] opt_rdata,
    output logic            opt_busy,
    output logic            mem_erase_req,
    output logic            core_run,
    output logic            pll_factor_sel,
    output logic            pll_bypass,
    output logic            rc_osc_disable,
    output logic [1:0]      supply_monitor_threshold,
    output logic            supply_monitor_enable,
    output logic            watchdog_type_sel,
    output logic            watchdog_force_on,
    output logic            halt_reset_enable,
    output logic [1:0]      sector0_size,
    output logic            readout_protect,
    output logic            program_write_protect,
    input  wire logic       sw_watchdog_en,
    input  wire logic       halt_entry,
    output logic            watchdog_active,
    output logic            halt_reset_req
);
    typedef struct packed {
        option_cfg_pkg::cfg_state_t state;
        logic [3:0]                 cnt;
        logic [7:0]                 nv0;     // Nonvolatile image, byte zero
        logic [7:0]                 nv1;     // Nonvolatile image, byte one
        logic [7:0]                 act0;    // Copy latched at reset
        logic [7:0]                 act1;
        logic                       sw_wdg;  // Software watchdog enable
        logic                       erase_pending;
        logic                       mem_erase;
        logic                       halt_rst;
        logic [7:0]                 rdata;
    } state_t;

    // Nonvolatile image starts at the shipped default; rst never touches it
    state_t cur_r = '{state: option_cfg_pkg::ST_RESET,
                      nv0:   option_cfg_pkg::CFG0_RESET,
                      nv1:   option_cfg_pkg::CFG1_RESET,
                      default: '0};
    state_t cur_nxt;
    logic   dec_wdg_sel;

    // Decode works on the latched copy so settings stay fixed while running
    option_field_decode u_decode (
        .cfg0                     (cur_r.act0),
        .cfg1                     (cur_r.act1),
        .pll_factor_sel           (pll_factor_sel),
        .pll_bypass               (pll_bypass),
        .rc_osc_disable           (rc_osc_disable),
        .supply_monitor_threshold (supply_monitor_threshold),
        .supply_monitor_enable    (supply_monitor_enable),
        .watchdog_type_sel        (dec_wdg_sel),
        .halt_reset_enable        (halt_reset_enable),
        .sector0_size             (sector0_size),
        .readout_protect          (readout_protect),
        .program_write_protect    (program_write_protect)
    );

    // Next-state logic
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.mem_erase = 1'b0;
        cur_nxt.halt_rst  = 1'b0;
        case (cur_r.state)
            option_cfg_pkg::ST_RESET: begin
                cur_nxt.state = option_cfg_pkg::ST_LOAD;
                cur_nxt.cnt   = 4'h0;
            end
            option_cfg_pkg::ST_LOAD: begin
                // Bytes captured before the core is released
                cur_nxt.act0 = cur_r.nv0;
                cur_nxt.act1 = cur_r.nv1;
                cur_nxt.cnt  = cur_r.cnt + 4'h1;
                if (cur_r.cnt == option_cfg_pkg::LOAD_CYCLES - 4'h1) begin
                    cur_nxt.state = option_cfg_pkg::ST_RUN;
                end
            end
            option_cfg_pkg::ST_RUN: begin
                if (prog_mode && !cur_r.nv0[option_cfg_pkg::WRP_BIT]) begin
                    if (opt_erase) begin
                        if (cur_r.nv0[option_cfg_pkg::RDP_BIT]) begin
                            // Protected memory is wiped before the bytes clear
                            cur_nxt.mem_erase     = 1'b1;
                            cur_nxt.erase_pending = 1'b1;
                            cur_nxt.state         = option_cfg_pkg::ST_ERASE;
                        end else begin
                            // Erase restores the unprotected shipped image
                            cur_nxt.nv0 = option_cfg_pkg::CFG0_RESET;
                            cur_nxt.nv1 = option_cfg_pkg::CFG1_RESET;
                        end
                    end else if (opt_wr) begin
                        // Whole byte stored; byte zero reserved bits held at 1
                        if (opt_sel) begin
                            cur_nxt.nv1 = opt_wdata;
                        end else begin
                            cur_nxt.nv0 = {option_cfg_pkg::RESERVED0_MASK, opt_wdata[3:0]};
                        end
                    end
                end
                // Software may enable the watchdog, never disable it
                if (sw_watchdog_en && !prog_mode) begin
                    cur_nxt.sw_wdg = 1'b1;
                end
                if (halt_entry && watchdog_active && halt_reset_enable) begin
                    cur_nxt.halt_rst = 1'b1;
                end
            end
            option_cfg_pkg::ST_ERASE: begin
                // An erased image must not lock the part, so no protection bits
                cur_nxt.nv0           = option_cfg_pkg::CFG0_RESET;
                cur_nxt.nv1           = option_cfg_pkg::CFG1_RESET;
                cur_nxt.erase_pending = 1'b0;
                cur_nxt.state         = option_cfg_pkg::ST_RUN;
            end
            default: begin
                cur_nxt.state = option_cfg_pkg::ST_RESET;
            end
        endcase
        // Read path; protected bytes still readable, memory is not
        cur_nxt.rdata = opt_sel ? cur_r.nv1 : cur_r.nv0;
    end

    // State register; nonvolatile image keeps its value across reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_r.state         <= option_cfg_pkg::ST_RESET;
            cur_r.cnt           <= 4'h0;
            cur_r.act0          <= option_cfg_pkg::CFG0_RESET;
            cur_r.act1          <= option_cfg_pkg::CFG1_RESET;
            cur_r.sw_wdg        <= 1'b0;
            cur_r.erase_pending <= 1'b0;
            cur_r.mem_erase     <= 1'b0;
            cur_r.halt_rst      <= 1'b0;
            cur_r.rdata         <= 8'h00;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Outputs
    assign opt_rdata         = cur_r.rdata;
    assign opt_busy          = (cur_r.state != option_cfg_pkg::ST_RUN);
    assign mem_erase_req     = cur_r.mem_erase;
    assign core_run          = (cur_r.state == option_cfg_pkg::ST_RUN);
    assign watchdog_type_sel = dec_wdg_sel;
    assign watchdog_force_on = !dec_wdg_sel;
    assign watchdog_active   = !dec_wdg_sel || cur_r.sw_wdg;
    assign halt_reset_req    = cur_r.halt_rst;
endmodule

// file: testbench/cfg_sva.sv
// Port checker for the option byte decoder
`timescale 1ns/10ps
module cfg_sva (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       opt_erase,
    input wire logic       prog_mode,
    input wire logic       opt_busy,
    input wire logic       mem_erase_req,
    input wire logic       core_run,
    input wire logic       pll_factor_sel,
    input wire logic [1:0] supply_monitor_threshold,
    input wire logic       supply_monitor_enable,
    input wire logic       watchdog_type_sel,
    input wire logic       watchdog_force_on,
    input wire logic       halt_reset_enable,
    input wire logic [1:0] sector0_size,
    input wire logic       sw_watchdog_en,
    input wire logic       halt_entry,
    input wire logic       watchdog_active,
    input wire logic       halt_reset_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Settings are fixed at reset and must not drift while the core runs
    run_start_a: assert property ($fell(rst) |-> !core_run ##[1:4] core_run)
        else $error("core run not raised after reset");
    cfg_hold_a: assert property (core_run && $past(core_run) |-> $stable(pll_factor_sel)
        && $stable(sector0_size)) else $error("decoded setting moved while running");
    smon_en_a: assert property (supply_monitor_enable == (supply_monitor_threshold != 2'h3))
        else $error("supply monitor enable wrong");
    wdg_force_a: assert property (watchdog_force_on == !watchdog_type_sel)
        else $error("watchdog force wrong");
    wdg_hw_a: assert property (core_run && !watchdog_type_sel |-> watchdog_active)
        else $error("hardware watchdog not active");
    watchdog_type_sel_a: assert property ($rose(watchdog_active) |-> !watchdog_type_sel
        || $past(sw_watchdog_en) || $past(sw_watchdog_en, 2)) else $error("watchdog self start");
    halt_rst_a: assert property (halt_entry && watchdog_active && halt_reset_enable
        |=> halt_reset_req) else $error("halt reset missing");
    halt_cause_a: assert property (halt_reset_req |-> $past(halt_entry)
        && $past(halt_reset_enable)) else $error("halt reset without cause");
    sec_code_a: assert property (sector0_size != 2'h0) else $error("sector size code");
    mem_erase_a: assert property (mem_erase_req |-> opt_busy && $past(opt_erase)
        && $past(prog_mode)) else $error("memory erase without erase request");
endmodule
bind option_byte_config_decode cfg_sva chk (.core_clk, .rst, .opt_erase, .prog_mode, .opt_busy,
    .mem_erase_req, .core_run, .pll_factor_sel, .supply_monitor_threshold,
    .supply_monitor_enable, .watchdog_type_sel, .watchdog_force_on, .halt_reset_enable,
    .sector0_size, .sw_watchdog_en, .halt_entry, .watchdog_active, .halt_reset_req);

// file: testbench/prog_tool.sv
// Programming tool model driving the option byte write port
`timescale 1ns/10ps
module prog_tool (
    input  wire logic       core_clk,
    output logic            prog_mode,
    output logic            opt_wr,
    output logic            opt_erase,
    output logic            opt_sel,
    output logic [7:0]      opt_wdata
);
    // Idle levels at time zero
    initial begin
        prog_mode = 1'b0;
        opt_wr = 1'b0;
        opt_erase = 1'b0;
        opt_sel = 1'b0;
        opt_wdata = 8'hA5;
    end
    // Mode settles on an edge before any access is made
    task automatic enter(input logic m);
        @(posedge core_clk) prog_mode <= m;
    endtask
    task automatic wr(input logic s, input logic [7:0] d);
        logic [7:0] x;
        x = s ? (d | 8'h20) : d;
        @(posedge core_clk);
        opt_sel <= s;
        opt_wdata <= x;
        opt_wr <= 1'b1;
        @(posedge core_clk);
        opt_wr <= 1'b0;
        opt_wdata <= ~x; // Released data carries junk, never the last value
    endtask
    task automatic erase();
        @(posedge core_clk) opt_erase <= 1'b1;
        @(posedge core_clk) opt_erase <= 1'b0;
        repeat (3) @(posedge core_clk); // Covers the busy cycle of a protected erase
    endtask
endmodule

// file: testbench/test_option_byte_config_decode.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/10ps
module test_option_byte_config_decode;
    logic       core_clk = 1'b0, rst = 1'b1, sw_watchdog_en = 1'b0, halt_entry = 1'b0;
    logic       prog_mode, opt_wr, opt_erase, opt_sel, opt_busy, mem_erase_req, core_run;
    logic       pll_factor_sel, pll_bypass, rc_osc_disable, supply_monitor_enable;
    logic       watchdog_type_sel, watchdog_force_on, halt_reset_enable, readout_protect;
    logic       program_write_protect, watchdog_active, halt_reset_req, erased;
    logic [1:0] supply_monitor_threshold, sector0_size;
    logic [7:0] opt_rdata, opt_wdata;
    logic [2:0] clk_opt [6] = '{3'h3, 3'h0, 3'h7, 3'h4, 3'h1, 3'h5};
    int         compares = 0, mismatches = 0;
    wire  [9:0] out1 = {1'b0, pll_factor_sel, pll_bypass, rc_osc_disable, supply_monitor_threshold,
        supply_monitor_enable, watchdog_type_sel, watchdog_force_on, halt_reset_enable};
    wire  [9:0] out0 = {6'h00, sector0_size, readout_protect, program_write_protect};
    prog_tool tool (.core_clk, .prog_mode, .opt_wr, .opt_erase, .opt_sel, .opt_wdata);
    option_byte_config_decode dut (.core_clk, .rst, .prog_mode, .opt_wr, .opt_erase, .opt_sel,
        .opt_wdata, .opt_rdata, .opt_busy, .mem_erase_req, .core_run,
        .pll_factor_sel, .pll_bypass, .rc_osc_disable, .supply_monitor_threshold,
        .supply_monitor_enable, .watchdog_type_sel, .watchdog_force_on, .halt_reset_enable,
        .sector0_size, .readout_protect, .program_write_protect, .sw_watchdog_en, .halt_entry,
        .watchdog_active, .halt_reset_req);
    always #25 core_clk = ~core_clk;
    // Erase pulses are one cycle wide, so catch them here
    always @(posedge core_clk) if (mem_erase_req === 1'b1) erased <= 1'b1;
    function automatic logic [9:0] dec1(input logic [7:0] d);
        return {1'b0, d[7], d[6], d[4], d[3:2], d[3:2] != 2'h3, d[1], !d[1], d[0]};
    endfunction
    function automatic logic [9:0] dec0(input logic [7:0] d);
        logic [1:0] s;
        s = d[3] ? option_cfg_pkg::SEC_ONE_HALF_K : d[2] ? option_cfg_pkg::SEC_ONE_K
            : option_cfg_pkg::SEC_HALF_K;
        return {6'h00, s, d[1:0]};
    endfunction
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reboot();
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 10 && core_run !== 1'b1; i++) @(posedge core_clk) #1;
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Random valid option sets; byte one is read back and both bytes are decoded after a reset
    initial begin
        logic [7:0] v, w;
        logic [2:0] c;
        logic       prev_rdp;
        v = $urandom(32'hDACA);
        prev_rdp = 1'b0;
        reboot();
        chk(out1, dec1(option_cfg_pkg::CFG1_RESET));
        chk(out0, dec0(option_cfg_pkg::CFG0_RESET));
        for (int n = 0; n < 6; n++) begin
            c = clk_opt[$urandom_range(5)];
            v = {c[0], c[1], 1'b1, c[2], 4'($urandom)};
            w = {4'hF, 2'($urandom), 1'($urandom), 1'b0};
            if (n == 0) v[3:0] = 4'h0; // Lowest threshold with hardware watchdog
            erased = 1'b0;
            tool.enter(1'b1);
            tool.erase();
            chk({9'h000, erased}, {9'h000, prev_rdp});
            tool.wr(1'b0, w);
            tool.wr(1'b1, v);
            tool.enter(1'b0);
            tool.wr(1'b1, 8'h00);
            repeat (2) @(posedge core_clk);
            #1 chk({2'h0, opt_rdata}, {2'h0, v});
            reboot();
            chk(out1, dec1(v));
            chk(out0, dec0(w));
            chk({9'h000, watchdog_active}, {9'h000, !v[1]});
            @(posedge core_clk) sw_watchdog_en <= 1'b1;
            @(posedge core_clk) sw_watchdog_en <= 1'b0;
            halt_entry <= 1'b1;
            @(posedge core_clk) halt_entry <= 1'b0;
            #1 chk({8'h00, watchdog_active, halt_reset_req}, {8'h00, 1'b1, v[0]});
            prev_rdp = w[1];
        end
        tool.enter(1'b1);
        tool.erase();
        tool.wr(1'b0, 8'hF1); // Write protection on, read-out protection off
        reboot();
        tool.wr(1'b1, 8'h00);
        tool.erase();
        repeat (2) @(posedge core_clk);
        #1 chk({2'h0, opt_rdata}, {2'h0, option_cfg_pkg::CFG1_RESET});
        chk({9'h000, program_write_protect}, 10'h001);
        close_out();
    end
    // Hang guard, well beyond the fewer than two hundred cycles the run needs
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
endmodule
